// *** rx_chan_capture.v ***
// Serial-to-parallel capture of one receive channel with its bit validity mask.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_regs.vh"
module rx_chan_capture (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Receiver bit stream
  input wire bit_strobe,
  input wire bit_value,
  input wire bit_valid,
  input wire frame_end,
  // Captured byte
  output reg [7:0] data_r,
  output reg [7:0] mask_r,
  output reg all_valid_r,
  output reg byte_load_r
);

  reg [`BIT_CNT_W-1:0] cnt_r;
  reg [7:0] shift_data_r;
  reg [7:0] shift_mask_r;
  reg [7:0] data_nxt;
  reg [7:0] mask_nxt;
  wire last_bit;

  assign last_bit = bit_strobe && (cnt_r == `BIT_CNT_LAST);

  // Merge the bit arriving now into the byte being assembled.
  always @* begin
    data_nxt = shift_data_r;
    mask_nxt = shift_mask_r;
    if (bit_strobe) begin
      data_nxt[cnt_r] = bit_value;
      mask_nxt[cnt_r] = bit_valid;
    end
  end

  // A frame end hands over a partial byte; bits never received read invalid.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= {`BIT_CNT_W{1'b0}};
      shift_data_r <= `RX_DATA_RESET;
      shift_mask_r <= `RX_MASK_RESET;
      data_r <= `RX_DATA_RESET;
      mask_r <= `RX_MASK_RESET;
      all_valid_r <= 1'b0;
      byte_load_r <= 1'b0;
    end else begin
      byte_load_r <= 1'b0;
      if (last_bit || frame_end) begin
        data_r <= data_nxt;
        mask_r <= mask_nxt;
        all_valid_r <= &mask_nxt;
        byte_load_r <= 1'b1;
        cnt_r <= {`BIT_CNT_W{1'b0}};
        shift_data_r <= `RX_DATA_RESET;
        shift_mask_r <= `RX_MASK_RESET;
      end else if (bit_strobe) begin
        cnt_r <= cnt_r + 3'h1;
        shift_data_r <= data_nxt;
        shift_mask_r <= mask_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// *** rx_radio_model.sv ***
// Radio receive stub that shifts bits into one receive channel.
`timescale 1ns/100ps
`default_nettype none
module rx_radio_model (
  input wire logic aclk,
  output logic strobe,
  output logic value,
  output logic valid,
  output logic frame_end
);
  initial begin
    strobe = 1'b0;
    value = 1'b0;
    valid = 1'b0;
    frame_end = 1'b0;
  end
  // Sends n bits, first bit first; a short frame closes with frame_end.
  task automatic send(input logic [7:0] d, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      strobe <= 1'b1;
      value <= d[i];
      valid <= m[i];
      @(posedge aclk);
      strobe <= 1'b0;
      // Between strobes the lines carry junk, never the last bit.
      value <= ~d[i];
      valid <= ~m[i];
    end
    if (n < 8) begin
      @(posedge aclk);
      frame_end <= 1'b1;
      @(posedge aclk);
      frame_end <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** serdes_checker_assertions.sv ***
// Port-level assertions for the SERDES register bank.
`timescale 1ns/100ps
`default_nettype none
module serdes_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Modes and flags
  input wire rx_mode_en,
  input wire tx_mode_en,
  input wire irq_r,
  input wire rx_a_all_valid_r,
  input wire rx_b_all_valid_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  a_write_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  a_read_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready while read data pending");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  a_irq_cause:
    assert property ($rose(irq_r) |-> $past(tx_mode_en, 2))
      else $error("irq rose outside transmit mode");
  a_irq_tx_off:
    assert property ((!tx_mode_en) [*3] |-> !irq_r)
      else $error("irq high with transmit mode off");
  a_flags_rx_off:
    assert property ((!rx_mode_en) [*2] |->
      !rx_a_all_valid_r && !rx_b_all_valid_r)
      else $error("all-valid flag with receive mode off");
endmodule
`default_nettype wire

// *** serdes_regs.vh ***
// Register map, field positions and reset values of the SERDES register bank.
`ifndef SERDES_REGS_VH
`define SERDES_REGS_VH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------------
`define RX_CHAN_A_VALID_MASK_IDX 8'h0A
`define RX_CHAN_B_DATA_BYTE_IDX 8'h0B
`define RX_CHAN_B_VALID_MASK_IDX 8'h0C
`define TX_IRQ_ENABLE_MASK_IDX 8'h0D
`define TX_IRQ_STATUS_IDX 8'h20
`define RX_ALL_VALID_STATUS_IDX 8'h21
`define ADDR_LSB 2
`define ADDR_IDX_W 8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TX_EMPTY_BIT 0
`define TX_DONE_BIT 1
`define TX_OVERFLOW_BIT 2
`define TX_UNDERFLOW_BIT 3
`define TX_FIELD_W 4
`define RX_ALL_VALID_A_BIT 0
`define RX_ALL_VALID_B_BIT 1

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define RX_MASK_RESET 8'h00
`define RX_DATA_RESET 8'h00
`define TX_IRQ_ENABLE_RESET 4'h0
`define TX_IRQ_STATUS_RESET 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BYTE_BITS 8
`define BIT_CNT_W 3
`define BIT_CNT_LAST 3'h7

`endif

// *** serdes_rx_valid_tx_irq_enable.v ***
// SERDES receive mask/data registers and transmit interrupt enable over AXI4-Lite.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_regs.vh"
module serdes_rx_valid_tx_irq_enable #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Mode enables from the radio control
  input wire rx_mode_en,
  input wire tx_mode_en,
  // Channel A receiver bit stream
  input wire rx_a_bit_strobe,
  input wire rx_a_bit_value,
  input wire rx_a_bit_valid,
  input wire rx_a_frame_end,
  // Channel B receiver bit stream
  input wire rx_b_bit_strobe,
  input wire rx_b_bit_value,
  input wire rx_b_bit_valid,
  input wire rx_b_frame_end,
  // Transmitter condition pulses
  input wire tx_underflow_evt,
  input wire tx_overflow_evt,
  input wire tx_done_evt,
  input wire tx_empty_evt,
  // Interrupt and receive flags
  output reg irq_r,
  output reg rx_a_all_valid_r,
  output reg rx_b_all_valid_r
);

  // --------------------------------------------------------------------------
  // Receive channels
  // --------------------------------------------------------------------------
  wire [1:0] ch_strobe;
  wire [1:0] ch_value;
  wire [1:0] ch_valid;
  wire [1:0] ch_end;
  wire [7:0] ch_data [0:1];
  wire [7:0] ch_mask [0:1];
  wire [1:0] ch_all_valid;
  wire [1:0] ch_load;

  assign ch_strobe = {rx_b_bit_strobe, rx_a_bit_strobe};
  assign ch_value = {rx_b_bit_value, rx_a_bit_value};
  assign ch_valid = {rx_b_bit_valid, rx_a_bit_valid};
  assign ch_end = {rx_b_frame_end, rx_a_frame_end};

  // Nothing is captured outside receive mode, so stale air bits never land.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      rx_chan_capture u_cap (
        .aclk(aclk),
        .aresetn(aresetn),
        .bit_strobe(ch_strobe[gi] & rx_mode_en),
        .bit_value(ch_value[gi]),
        .bit_valid(ch_valid[gi]),
        .frame_end(ch_end[gi] & rx_mode_en),
        .data_r(ch_data[gi]),
        .mask_r(ch_mask[gi]),
        .all_valid_r(ch_all_valid[gi]),
        .byte_load_r(ch_load[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Transmit interrupt enable and sticky status
  // --------------------------------------------------------------------------
  reg [`TX_FIELD_W-1:0] tx_irq_enable_r;
  reg [`TX_FIELD_W-1:0] tx_irq_status_r;
  reg [`TX_FIELD_W-1:0] tx_irq_status_nxt;
  wire [`TX_FIELD_W-1:0] tx_evt;
  wire [`TX_FIELD_W-1:0] tx_clear;
  wire [`TX_FIELD_W-1:0] tx_pending;

  // Events are dropped while the transmitter is off, so its status reads zero.
  assign tx_evt[`TX_UNDERFLOW_BIT] = tx_underflow_evt & tx_mode_en;
  assign tx_evt[`TX_OVERFLOW_BIT] = tx_overflow_evt & tx_mode_en;
  assign tx_evt[`TX_DONE_BIT] = tx_done_evt & tx_mode_en;
  assign tx_evt[`TX_EMPTY_BIT] = tx_empty_evt & tx_mode_en;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  reg aw_held_r;
  reg w_held_r;
  reg [`ADDR_IDX_W-1:0] aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire aw_take;
  wire w_take;
  wire [`ADDR_IDX_W-1:0] aw_idx_now;
  wire [`ADDR_IDX_W-1:0] wr_idx;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_fire;
  wire wr_lane0;
  wire wr_hit_enable;
  wire wr_hit_status;
  wire wr_mapped;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign aw_idx_now = s_axi_awaddr[`ADDR_LSB+`ADDR_IDX_W-1:`ADDR_LSB];
  assign wr_idx = aw_held_r ? aw_idx_r : aw_idx_now;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_fire = (aw_held_r | aw_take) & (w_held_r | w_take) &
                   ~s_axi_bvalid;
  assign wr_lane0 = wr_fire & wr_strb[0];
  assign wr_hit_enable = (wr_idx == `TX_IRQ_ENABLE_MASK_IDX);
  assign wr_hit_status = (wr_idx == `TX_IRQ_STATUS_IDX);
  // Read-only places take the write and ignore it; unknown places get SLVERR.
  assign wr_mapped = wr_hit_enable | wr_hit_status |
                     (wr_idx == `RX_CHAN_A_VALID_MASK_IDX) |
                     (wr_idx == `RX_CHAN_B_DATA_BYTE_IDX) |
                     (wr_idx == `RX_CHAN_B_VALID_MASK_IDX) |
                     (wr_idx == `RX_ALL_VALID_STATUS_IDX);

  assign tx_clear = (wr_lane0 & wr_hit_status) ?
                    wr_data[`TX_FIELD_W-1:0] : {`TX_FIELD_W{1'b0}};

  // A new event outranks a clear arriving in the same cycle.
  always @* begin
    tx_irq_status_nxt = (tx_irq_status_r & ~tx_clear) | tx_evt;
  end

  assign tx_pending = tx_irq_status_r & tx_irq_enable_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= {`ADDR_IDX_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      tx_irq_enable_r <= `TX_IRQ_ENABLE_RESET;
      tx_irq_status_r <= `TX_IRQ_STATUS_RESET;
    end else begin
      // Status is forced clear while the transmitter is off.
      if (!tx_mode_en) begin
        tx_irq_status_r <= `TX_IRQ_STATUS_RESET;
      end else begin
        tx_irq_status_r <= tx_irq_status_nxt;
      end
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= aw_idx_now;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_lane0 && wr_hit_enable) begin
          // Upper bits are reserved and dropped; they always read zero.
          tx_irq_enable_r <= wr_data[`TX_FIELD_W-1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Ready is offered one cycle ahead and dropped once a beat is held.
      s_axi_awready <= ~(aw_held_r | aw_take) & ~wr_fire & ~s_axi_bvalid;
      s_axi_wready <= ~(w_held_r | w_take) & ~wr_fire & ~s_axi_bvalid;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  reg [31:0] rd_word;
  reg rd_ok;
  wire [`ADDR_IDX_W-1:0] ar_idx;
  wire ar_take;

  assign ar_idx = s_axi_araddr[`ADDR_LSB+`ADDR_IDX_W-1:`ADDR_LSB];
  assign ar_take = s_axi_arvalid & s_axi_arready;

  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (ar_idx)
      `RX_CHAN_A_VALID_MASK_IDX: begin
        rd_word[7:0] = ch_mask[0];
      end
      `RX_CHAN_B_DATA_BYTE_IDX: begin
        rd_word[7:0] = ch_data[1];
      end
      `RX_CHAN_B_VALID_MASK_IDX: begin
        rd_word[7:0] = ch_mask[1];
      end
      `TX_IRQ_ENABLE_MASK_IDX: begin
        rd_word[`TX_FIELD_W-1:0] = tx_irq_enable_r;
      end
      `TX_IRQ_STATUS_IDX: begin
        rd_word[`TX_FIELD_W-1:0] = tx_irq_status_r;
      end
      `RX_ALL_VALID_STATUS_IDX: begin
        rd_word[`RX_ALL_VALID_A_BIT] = rx_a_all_valid_r;
        rd_word[`RX_ALL_VALID_B_BIT] = rx_b_all_valid_r;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Only one read is under way, so ready waits for the answer to go.
      // The toggle costs a read at most one idle cycle before it is taken.
      s_axi_arready <= ~ar_take & ~s_axi_rvalid & ~s_axi_arready;
    end
  end

  // --------------------------------------------------------------------------
  // Receive flags
  // --------------------------------------------------------------------------
  // The all-valid flags follow the last stored byte and never drive irq_r.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_a_all_valid_r <= 1'b0;
      rx_b_all_valid_r <= 1'b0;
    end else begin
      if (!rx_mode_en) begin
        rx_a_all_valid_r <= 1'b0;
        rx_b_all_valid_r <= 1'b0;
      end else begin
        if (ch_load[0]) begin
          rx_a_all_valid_r <= ch_all_valid[0];
        end
        if (ch_load[1]) begin
          rx_b_all_valid_r <= ch_all_valid[1];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------------------
  // Registered so the pin never glitches; it trails the status by one cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (tx_pending[`TX_UNDERFLOW_BIT] |
                tx_pending[`TX_OVERFLOW_BIT] |
                tx_pending[`TX_DONE_BIT] |
                tx_pending[`TX_EMPTY_BIT]);
    end
  end

endmodule
`default_nettype wire

// *** serdes_rx_valid_tx_irq_enable_bench.sv ***
// Self-checking bench for the SERDES register bank.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_regs.vh"
module serdes_rx_valid_tx_irq_enable_bench;
  localparam [11:0] A_MASK = `RX_CHAN_A_VALID_MASK_IDX * 4;
  localparam [11:0] B_DATA = `RX_CHAN_B_DATA_BYTE_IDX * 4;
  localparam [11:0] B_MASK = `RX_CHAN_B_VALID_MASK_IDX * 4;
  localparam [11:0] EN = `TX_IRQ_ENABLE_MASK_IDX * 4;
  localparam [11:0] STAT = `TX_IRQ_STATUS_IDX * 4;
  localparam [11:0] ALLV = `RX_ALL_VALID_STATUS_IDX * 4;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irq_r;
  logic [1:0] bresp, rresp;
  logic rx_mode_en = 1'b0, tx_mode_en = 1'b0;
  logic [3:0] tx_evt = 4'h0;
  logic a_stb, a_val, a_vld, a_fe, b_stb, b_val, b_vld, b_fe, a_all, b_all;
  int n_fail = 0, check_count = 0;
  always #4 aclk = ~aclk;
  serdes_rx_valid_tx_irq_enable serdes_rx_valid_tx_irq_enable_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_mode_en(rx_mode_en), .tx_mode_en(tx_mode_en),
    .rx_a_bit_strobe(a_stb), .rx_a_bit_value(a_val),
    .rx_a_bit_valid(a_vld), .rx_a_frame_end(a_fe),
    .rx_b_bit_strobe(b_stb), .rx_b_bit_value(b_val),
    .rx_b_bit_valid(b_vld), .rx_b_frame_end(b_fe),
    .tx_underflow_evt(tx_evt[3]), .tx_overflow_evt(tx_evt[2]),
    .tx_done_evt(tx_evt[1]), .tx_empty_evt(tx_evt[0]), .irq_r(irq_r),
    .rx_a_all_valid_r(a_all), .rx_b_all_valid_r(b_all));
  rx_radio_model rx_radio_model_inst (.aclk(aclk), .strobe(a_stb),
    .value(a_val), .valid(a_vld), .frame_end(a_fe));
  rx_radio_model rx_radio_model_inst_b (.aclk(aclk), .strobe(b_stb),
    .value(b_val), .valid(b_vld), .frame_end(b_fe));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    cmp32({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    v = rdata;
    cmp32({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic pulse(input logic [3:0] e);
    @(posedge aclk);
    tx_evt <= e;
    @(posedge aclk);
    tx_evt <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rx_mode_en <= 1'b1;
    tx_mode_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(A_MASK + 4 * i, d, `RESP_OKAY);
      cmp32(d, 32'h0);
    end
    rx_radio_model_inst_b.send(8'hA5, 8'hFF, 8);
    repeat (4) @(posedge aclk);
    rd(B_DATA, d, `RESP_OKAY);
    cmp32(d, 32'hA5);
    rd(B_MASK, d, `RESP_OKAY);
    cmp32(d, 32'hFF);
    cmp1(b_all, 1'b1);
    cmp1(irq_r, 1'b0);
    rd(ALLV, d, `RESP_OKAY);
    cmp32(d, 32'h2);
    rx_radio_model_inst.send(8'h0D, 8'hFB, 5);
    repeat (4) @(posedge aclk);
    rd(A_MASK, d, `RESP_OKAY);
    cmp32(d, 32'h1B);
    cmp1(a_all, 1'b0);
    rx_radio_model_inst.send(8'h3C, 8'hFF, 8);
    repeat (4) @(posedge aclk);
    rd(A_MASK, d, `RESP_OKAY);
    cmp32(d, 32'hFF);
    cmp1(a_all, 1'b1);
    // Read-only and unmapped places must leave the map untouched.
    wr(B_DATA, 32'h0, `RESP_OKAY);
    wr(12'h03C, 32'hFF, `RESP_SLVERR);
    rd(B_DATA, d, `RESP_OKAY);
    cmp32(d, 32'hA5);
    wr(EN, 32'h0F, `RESP_OKAY);
    rd(EN, d, `RESP_OKAY);
    cmp32(d, 32'h0F);
    for (int i = 0; i < 4; i++) begin
      wr(EN, 32'h1 << i, `RESP_OKAY);
      pulse(4'h1 << ((i + 1) % 4));
      cmp1(irq_r, 1'b0);
      rd(STAT, d, `RESP_OKAY);
      cmp32(d, 32'h1 << ((i + 1) % 4));
      pulse(4'h1 << i);
      cmp1(irq_r, 1'b1);
      wr(STAT, 32'h0F, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      cmp1(irq_r, 1'b0);
    end
    // Leaving a mode clears its flags; a set outranks a clear in one cycle.
    wr(EN, 32'h0F, `RESP_OKAY);
    pulse(4'h8);
    cmp1(irq_r, 1'b1);
    tx_mode_en <= 1'b0;
    rx_mode_en <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp1(irq_r, 1'b0);
    cmp1(a_all, 1'b0);
    cmp1(b_all, 1'b0);
    pulse(4'hF);
    rd(STAT, d, `RESP_OKAY);
    cmp32(d, 32'h0);
    rd(ALLV, d, `RESP_OKAY);
    cmp32(d, 32'h0);
    tx_mode_en <= 1'b1;
    pulse(4'h1);
    fork
      wr(STAT, 32'h0F, `RESP_OKAY);
      pulse(4'h4);
    join
    rd(STAT, d, `RESP_OKAY);
    cmp32(d, 32'h4);
    cmp1(irq_r, 1'b1);
    end_of_test();
  end
endmodule
bind serdes_rx_valid_tx_irq_enable serdes_checker serdes_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .rx_mode_en(rx_mode_en),
  .tx_mode_en(tx_mode_en), .irq_r(irq_r),
  .rx_a_all_valid_r(rx_a_all_valid_r), .rx_b_all_valid_r(rx_b_all_valid_r));
`default_nettype wire
